// ==== rtl/arl_timer.sv ====
// 8-bit auto-reload timer: prescaler, counter, overflow flag, capture interrupts, apb slave
// assumes apb from a master on core_clk_i and pins synchronous to that clock
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "arl_cfg.svh"
module arl_timer
(
   // clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 reset_n_i,
   // register bus
   input  wire arl_pkg::arl_apb_req_t apb_i,
   output arl_pkg::arl_apb_rsp_t      apb_o,
   // pins and mode
   input  wire logic                 ext_clk_i,
   input  wire logic [1:0]           capture_input_pin_i,
   input  wire logic                 halt_i,
   // interrupt
   output logic                      irq_o
);
   import arl_pkg::*;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // register state
   arl_csr_t                     csr_q, csr_d;             // control/status
   logic [7:0]                   cnt_q, cnt_d;             // running counter
   logic [7:0]                   reload_q, reload_d;       // reload value
   logic [`ARL_PRESC_W-1:0]      presc_q, presc_d;         // prescaler
   logic [`ARL_CAP_CH-1:0]       cap_edge_q, cap_edge_d;   // edge polarity per channel
   logic [`ARL_CAP_CH-1:0]       cap_ie_q, cap_ie_d;       // capture enable per channel
   logic [`ARL_IRQ_W-1:0]        irq_stat_q, irq_stat_d;   // sticky events
   logic [`ARL_IRQ_W-1:0]        irq_mask_q, irq_mask_d;   // event mask
   logic                         ext_prev_q, ext_prev_d;   // last external clock level
   logic [31:0]                  prdata_q, prdata_d;       // read data
   logic                         slverr_q, slverr_d;       // unmapped address

   // bus decode
   logic        setup, access, wr, rd;
   logic        sel_csr, sel_cnt, sel_rel, sel_cap, sel_ist, sel_imk, mapped;
   // timing
   logic        ext_rise, in_pulse, tick, force_ld, cnt_wr, at_max, ovf_evt, rd_clr;
   logic [7:0]  mask8;
   logic [`ARL_PRESC_W-1:0] presc_mask;
   logic        cap_sample;
   logic [`ARL_CAP_CH-1:0]  cap_evt;
   logic [`ARL_IRQ_W-1:0]   irq_evt, irq_w1c, irq_gate;

   // apb phases; writes and clears take effect only at the access edge
   assign setup   = apb_i.psel && !apb_i.penable;
   assign access  = apb_i.psel && apb_i.penable;
   assign wr      = access && apb_i.pwrite;
   assign rd      = access && !apb_i.pwrite;
   assign sel_csr = (apb_i.paddr == `ARL_OFS_CSR);
   assign sel_cnt = (apb_i.paddr == `ARL_OFS_CNT);
   assign sel_rel = (apb_i.paddr == `ARL_OFS_RELOAD);
   assign sel_cap = (apb_i.paddr == `ARL_OFS_CAP);
   assign sel_ist = (apb_i.paddr == `ARL_OFS_IRQ_STAT);
   assign sel_imk = (apb_i.paddr == `ARL_OFS_IRQ_MASK);
   assign mapped  = sel_csr || sel_cnt || sel_rel || sel_cap || sel_ist || sel_imk;

   // zero wait states: read data is latched in setup, so pready may stay high
   assign apb_o = '{pready:  1'b1,
                    pslverr: slverr_q,
                    prdata:  prdata_q};

   // prescaler input: every core cycle, or a rising edge of the external clock
   assign ext_rise = ext_clk_i && !ext_prev_q;
   assign in_pulse = csr_q.ext_clock_select ? ext_rise : 1'b1;

   // tick when the low prescale_select bits of the prescaler are all ones
   assign mask8      = (8'h01 << csr_q.prescale_select) - 8'h01;
   assign presc_mask = mask8[`ARL_PRESC_W-1:0];
   assign tick       = csr_q.count_run && in_pulse &&
                       ((presc_q & presc_mask) == presc_mask);

   // software loads win over a tick in the same cycle
   assign force_ld = wr && sel_csr && apb_i.pwdata[`ARL_CSR_FORCE_RELOAD_BIT];
   assign cnt_wr   = wr && sel_cnt;
   assign at_max   = (cnt_q == `ARL_CNT_MAX);
   assign ovf_evt  = tick && at_max && !force_ld && !cnt_wr;

   // clear only what the read returned, so a flag set after setup is kept
   assign rd_clr = rd && sel_csr && prdata_q[`ARL_CSR_OVF_BIT];

   // prescaler and counter next values
   always_comb
   begin
      presc_d = presc_q;
      cnt_d   = cnt_q;
      if (force_ld)
      begin
         presc_d = '0;
         cnt_d   = reload_q;
      end
      else
      begin
         if (csr_q.count_run && in_pulse)
         begin
            presc_d = tick ? '0 : presc_q + 7'h01;
         end
         if (cnt_wr)
         begin
            cnt_d = apb_i.pwdata[7:0];
         end
         else if (tick)
         begin
            cnt_d = at_max ? reload_q : cnt_q + 8'h01;
         end
      end
   end

   // control, reload and capture configuration next values
   always_comb
   begin
      csr_d      = csr_q;
      reload_d   = reload_q;
      cap_edge_d = cap_edge_q;
      cap_ie_d   = cap_ie_q;
      irq_mask_d = irq_mask_q;
      ext_prev_d = ext_clk_i;
      if (wr && sel_csr)
      begin
         // all fields at once, by the struct layout; strobe and flag are overridden below
         csr_d = arl_csr_t'(apb_i.pwdata[7:0]);
      end
      // force reload is a strobe and is never stored
      csr_d.force_reload  = 1'b0;
      // set wins over the read clear
      csr_d.overflow_flag = ovf_evt || (csr_q.overflow_flag && !rd_clr);
      if (wr && sel_rel)
      begin
         reload_d = apb_i.pwdata[7:0];
      end
      if (wr && sel_cap)
      begin
         cap_edge_d = apb_i.pwdata[`ARL_CAP_EDGE_LSB +: `ARL_CAP_CH];
         cap_ie_d   = apb_i.pwdata[`ARL_CAP_IE_LSB +: `ARL_CAP_CH];
      end
      if (wr && sel_imk)
      begin
         irq_mask_d = apb_i.pwdata[`ARL_IRQ_W-1:0];
      end
   end

   // capture channels; sample on every timer tick, and on every core cycle while in halt
   assign cap_sample = tick || halt_i;

   genvar ch;
   generate
      for (ch = 0; ch < `ARL_CAP_CH; ch = ch + 1)
      begin : g_cap
         arl_edge_chan u_chan
         (
            .core_clk_i            (core_clk_i),
            .reset_n_i             (reset_n_i),
            .capture_input_pin_i   (capture_input_pin_i[ch]),
            .sample_en_i           (cap_sample),
            .capture_edge_select_i (cap_edge_q[ch]),
            .edge_o                (cap_evt[ch])
         );
      end
   endgenerate

   // sticky events, write one to clear; a new event in the clear cycle survives
   assign irq_evt = {cap_evt, ovf_evt};
   assign irq_w1c = (wr && sel_ist) ? apb_i.pwdata[`ARL_IRQ_W-1:0] : '0;
   assign irq_stat_d = irq_evt | (irq_stat_q & ~irq_w1c);

   // interrupt: overflow flag gated by its enable, captures by their enables and mask
   assign irq_gate = irq_stat_q & irq_mask_q & {cap_ie_q, 1'b0};
   assign irq_o    = (csr_q.overflow_flag && csr_q.overflow_irq_enable) ||
                     (|irq_gate);

   // read mux, sampled in the setup cycle
   always_comb
   begin
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (setup)
      begin
         prdata_d = `ARL_WORD_RST;
         slverr_d = !mapped;
         if (!apb_i.pwrite)
         begin
            if (sel_csr)
            begin
               prdata_d[7:0] = csr_q;                 // force bit stored as zero
            end
            else if (sel_cnt)
            begin
               prdata_d[7:0] = cnt_q;
            end
            else if (sel_rel)
            begin
               prdata_d[7:0] = reload_q;
            end
            else if (sel_cap)
            begin
               prdata_d[`ARL_CAP_EDGE_LSB +: `ARL_CAP_CH] = cap_edge_q;
               prdata_d[`ARL_CAP_IE_LSB +: `ARL_CAP_CH]   = cap_ie_q;
               prdata_d[`ARL_CAP_FLAG_LSB +: `ARL_CAP_CH] =
                  irq_stat_q[`ARL_IRQ_CAP_LSB +: `ARL_CAP_CH];
            end
            else if (sel_ist)
            begin
               prdata_d[`ARL_IRQ_W-1:0] = irq_stat_q;
            end
            else if (sel_imk)
            begin
               prdata_d[`ARL_IRQ_W-1:0] = irq_mask_q;
            end
         end
      end
   end

   // register everything
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         csr_q      <= `ARL_CSR_RST;
         cnt_q      <= `ARL_BYTE_RST;
         reload_q   <= `ARL_BYTE_RST;
         presc_q    <= '0;
         cap_edge_q <= '0;
         cap_ie_q   <= '0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         ext_prev_q <= 1'b0;
         prdata_q   <= `ARL_WORD_RST;
         slverr_q   <= 1'b0;
      end
      else
      begin
         csr_q      <= csr_d;
         cnt_q      <= cnt_d;
         reload_q   <= reload_d;
         presc_q    <= presc_d;
         cap_edge_q <= cap_edge_d;
         cap_ie_q   <= cap_ie_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         ext_prev_q <= ext_prev_d;
         prdata_q   <= prdata_d;
         slverr_q   <= slverr_d;
      end
   end

   // sequences used by the checks
   sequence s_wrap;
      tick && at_max && !force_ld && !cnt_wr;
   endsequence
   sequence s_div2;
      tick && csr_q.prescale_select == 3'h1;
   endsequence
   sequence s_halt_rise0;
      halt_i ##1 (halt_i && $rose(capture_input_pin_i[0]) && cap_edge_q[0]);
   endsequence

   cpu_clock_tick_a: assert property (
      (!csr_q.ext_clock_select && csr_q.count_run && csr_q.prescale_select == 3'h0) |-> tick)
      else $error("cpu clock at divide by one did not tick");
   ext_no_edge_a: assert property (
      (csr_q.ext_clock_select && !(ext_clk_i && !$past(ext_clk_i))) |-> !tick)
      else $error("tick without external clock edge");
   div_two_a: assert property (
      s_div2 |=> (!tick || csr_q.prescale_select != 3'h1))
      else $error("divide by two ticked twice in a row");
   freeze_hold_a: assert property (
      (!csr_q.count_run && !force_ld && !cnt_wr) |=> ($stable(cnt_q) && $stable(presc_q)))
      else $error("stopped timer moved");
   force_reload_reads_zero_a: assert property (
      (setup && sel_csr && !apb_i.pwrite) |=> !prdata_q[`ARL_CSR_FORCE_RELOAD_BIT])
      else $error("force reload bit read as one");
   force_load_a: assert property (
      force_ld |=> (cnt_q == $past(reload_q) && presc_q == '0))
      else $error("force reload did not load counter");
   ovf_irq_gate_a: assert property (
      (csr_q.overflow_flag && !csr_q.overflow_irq_enable && irq_gate == '0) |-> !irq_o)
      else $error("overflow irq while disabled");
   ovf_set_a: assert property (
      s_wrap |=> csr_q.overflow_flag [*1] ##0 (cnt_q == $past(reload_q)))
      else $error("overflow flag or reload missing");
   ovf_read_clr_a: assert property (
      (rd_clr && !ovf_evt) |=> !csr_q.overflow_flag)
      else $error("overflow flag survived its read");
   cap_enable_a: assert property (
      (cap_ie_q == '0) |-> (irq_o == (csr_q.overflow_flag && csr_q.overflow_irq_enable)))
      else $error("capture irq while capture disabled");
   halt_capture_a: assert property (
      s_halt_rise0 |=> irq_stat_q[`ARL_IRQ_CAP_LSB])
      else $error("halt capture edge lost");
   cnt_access_a: assert property (
      (cnt_wr && !force_ld) |=> cnt_q == $past(apb_i.pwdata[7:0]))
      else $error("counter write lost");
   ovf_irq_a: assert property (
      (csr_q.overflow_flag && csr_q.overflow_irq_enable) |-> irq_o)
      else $error("overflow irq missing");
   cnt_step_a: assert property (
      (tick && !at_max && !force_ld && !cnt_wr) |=> cnt_q == 8'($past(cnt_q) + 8'h01))
      else $error("counter did not step by one");
endmodule

// ==== rtl/arl_cfg.svh ====
// register offsets, field positions, reset values and fixed sizes of the reload timer
// assumes a 12-bit byte address on the register bus and 32-bit data words
`ifndef ARL_CFG_SVH
`define ARL_CFG_SVH

// byte offsets of the registers
`define ARL_OFS_CSR      12'h000
`define ARL_OFS_CNT      12'h004
`define ARL_OFS_RELOAD   12'h008
`define ARL_OFS_CAP      12'h00c
`define ARL_OFS_IRQ_STAT 12'h010
`define ARL_OFS_IRQ_MASK 12'h014

// control/status field positions
`define ARL_CSR_FORCE_RELOAD_BIT 2
`define ARL_CSR_OVF_BIT  0

// capture control/status field positions (two channels)
`define ARL_CAP_EDGE_LSB 0
`define ARL_CAP_IE_LSB   2
`define ARL_CAP_FLAG_LSB 4

// interrupt status layout: overflow event, then one bit per capture channel
`define ARL_IRQ_OVF_BIT  0
`define ARL_IRQ_CAP_LSB  1

// sizes and reset values
`define ARL_CAP_CH       2
`define ARL_IRQ_W        3
`define ARL_PRESC_W      7
`define ARL_CSR_RST      8'h00
`define ARL_BYTE_RST     8'h00
`define ARL_CNT_MAX      8'hff
`define ARL_WORD_RST     32'h0000_0000

`endif

// ==== rtl/arl_pkg.sv ====
// types shared by the reload timer files
// assumes the constants of arl_cfg.svh for field sizes
`include "arl_cfg.svh"
package arl_pkg;

   // control/status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       ext_clock_select;
      logic [2:0] prescale_select;
      logic       count_run;
      logic       force_reload;
      logic       overflow_irq_enable;
      logic       overflow_flag;
   } arl_csr_t;

   // apb request from the bus master
   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } arl_apb_req_t;

   // apb answer to the bus master
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } arl_apb_rsp_t;

endpackage

// ==== rtl/arl_edge_chan.sv ====
// one capture channel: edge detector on a capture input pin with selectable polarity
// assumes the pin is synchronous to the core clock; sampling is gated by sample_en_i
`timescale 1ns/100ps
module arl_edge_chan
(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   // pin and sampling
   input  wire logic capture_input_pin_i,
   input  wire logic sample_en_i,
   input  wire logic capture_edge_select_i,
   // detected edge, one cycle
   output logic      edge_o
);
   logic prev_q;   // pin level at the last sample
   logic prev_d;
   logic seen_q;   // a first sample was taken since reset
   logic seen_d;

   // the first sample only primes prev_q, so a pin idling high gives no false edge
   assign seen_d = seen_q || sample_en_i;

   // next sample: only moves on the sampling enable, so slow ticks see slow edges
   always_comb
   begin
      prev_d = prev_q;
      if (sample_en_i)
      begin
         prev_d = capture_input_pin_i;
      end
   end

   // register the sample
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prev_q <= 1'b0;
         seen_q <= 1'b0;
      end
      else
      begin
         prev_q <= prev_d;
         seen_q <= seen_d;
      end
   end

   // edge when the level changed to the selected one (1 picks rising)
   assign edge_o = sample_en_i && seen_q && (capture_input_pin_i != prev_q) &&
                   (capture_input_pin_i == capture_edge_select_i);
endmodule

// ==== sim/arl_pins_model.sv ====
// pin-side partner: external timer clock source and the two capture pins
// assumes the bench calls its tasks; every pin moves just after a rising core edge
`timescale 1ns/100ps
module arl_pins_model
(
   // clock
   input  wire logic  core_clk_i,
   // pins toward the timer
   output logic       ext_clk_o,
   output logic [1:0] pins_o
);
   // the external clock stands low between bursts, like a gated source
   initial ext_clk_o = 1'b0;
   // channel 1 idles high so that its falling edge can be shown
   initial pins_o = 2'b10;

   // burst of rising edges; each high is held two cycles and each low three, so none is lost
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge core_clk_i) ext_clk_o <= 1'b1;
         repeat (2) @(posedge core_clk_i);
         ext_clk_o <= 1'b0;
         repeat (2) @(posedge core_clk_i);
      end
   endtask

   // move the pins, then give the edge detector time to see the change
   task automatic set_pins(input logic [1:0] v);
      @(posedge core_clk_i) pins_o <= v;
      repeat (3) @(posedge core_clk_i);
   endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench of the reload timer: apb master, read-note queue, pin partner
// assumes arl_cfg.svh offsets and the zero-wait apb slave of the timer
`timescale 1ns/100ps
`include "arl_cfg.svh"
module tb;
   import arl_pkg::*;

   // expected read: allowed value range and error bit
   typedef struct {
      logic [11:0] a;
      logic [7:0]  lo;
      logic [7:0]  hi;
      logic        err;
   } arl_note_t;

   logic         core_clk_i;   // core clock, 125 mhz
   logic         reset_n_i;    // async reset, active low
   logic         halt;         // halt mode level
   logic         irq;          // interrupt output
   logic         ext_clk;      // external timer clock from the partner
   logic [1:0]   pins;         // capture pins from the partner
   arl_apb_req_t req;          // apb request driven by the bench
   arl_apb_rsp_t rsp;          // apb answer
   arl_note_t    notes[$];     // pending read expectations
   arl_note_t    cur;          // note being compared
   int           fail_count;   // mismatches
   int           checked;      // comparisons made
   logic [31:0]  rnd;          // lfsr state
   logic [7:0]   v;            // random byte in use

   arl_timer dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .apb_i(req), .apb_o(rsp),
      .ext_clk_i(ext_clk), .capture_input_pin_i(pins), .halt_i(halt), .irq_o(irq));
   arl_pins_model pm (.core_clk_i(core_clk_i), .ext_clk_o(ext_clk), .pins_o(pins));

   // free-running clock
   initial core_clk_i = 1'b0;
   always #4 core_clk_i = ~core_clk_i;

   // galois lfsr step
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
   endfunction

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge core_clk_i);
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= {24'h00_0000, d};
      req.psel <= 1'b1;
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      do @(posedge core_clk_i); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask

   // a read notes its expectation first; the monitor compares it
   task automatic rd(input logic [11:0] a, input logic [7:0] lo, input logic [7:0] hi,
                     input logic e);
      notes.push_back('{a, lo, hi, e});
      bus(a, 1'b0, 8'h00);
   endtask

   // interrupt level, looked at mid-cycle once edge updates have landed
   task automatic chk_irq(input logic e);
      @(negedge core_clk_i);
      checked++;
      if (irq !== e)
      begin
         fail_count++;
         $display("CHECK FAILED irq_o expected %b seen %b", e, irq);
      end
   endtask

   // read data is taken at the completing access edge, oldest note first
   always @(posedge core_clk_i)
      if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
      begin
         cur = notes.pop_front();
         checked++;
         if (((rsp.prdata >= {24'h0, cur.lo}) && (rsp.prdata <= {24'h0, cur.hi})) !== 1'b1 ||
             rsp.pslverr !== cur.err)
         begin
            fail_count++;
            $display("CHECK FAILED read %h expected %h..%h err %b seen %h err %b",
                     cur.a, cur.lo, cur.hi, cur.err, rsp.prdata, rsp.pslverr);
         end
      end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // watchdog: the whole sequence needs about a thousand cycles
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      fail_count++;
      wrap_up();
   end

   initial
   begin
      req = '0;
      halt = 1'b0;
      reset_n_i = 1'b0;
      rnd = 32'h864c_e723;
      fail_count = 0;
      checked = 0;
      repeat (2) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      // reset values, unmapped place
      rd(`ARL_OFS_CSR, 8'h00, 8'h00, 1'b0);
      for (int i = 1; i < 6; i++)
         rd(12'(i * 4), 8'h00, 8'h00, 1'b0);
      wr(12'h018, 8'h5a);
      rd(12'h018, 8'h00, 8'h00, 1'b1);
      chk_irq(1'b0);
      $display("test reset done");
      // control bits read back, reload strobe reads zero
      wr(`ARL_OFS_CSR, 8'hf6);
      rd(`ARL_OFS_CSR, 8'hf2, 8'hf2, 1'b0);
      wr(`ARL_OFS_CSR, 8'h00);
      // forced reload and frozen counter, random values
      rnd = lfsr(rnd);
      v = rnd[7:0];
      wr(`ARL_OFS_RELOAD, v);
      wr(`ARL_OFS_CSR, 8'h04);
      rd(`ARL_OFS_CNT, v, v, 1'b0);
      rnd = lfsr(rnd);
      v = rnd[7:0];
      wr(`ARL_OFS_CNT, v);
      repeat (20) @(posedge core_clk_i);
      rd(`ARL_OFS_CNT, v, v, 1'b0);
      $display("test reload done");
      // every prescale code: three ticks' worth of cycles gives about three counts
      wr(`ARL_OFS_RELOAD, 8'h00);
      for (int s = 0; s < 8; s++)
      begin
         wr(`ARL_OFS_CSR, {1'b0, 3'(s), 4'hc});
         repeat ((3 << s) - 2) @(posedge core_clk_i);
         wr(`ARL_OFS_CSR, {1'b0, 3'(s), 4'h0});
         rd(`ARL_OFS_CNT, 8'h02, 8'h04, 1'b0);
      end
      $display("test prescale done");
      // overflow with the interrupt off, then on, then read-clear
      wr(`ARL_OFS_RELOAD, 8'hfd);
      wr(`ARL_OFS_CSR, 8'h0c);
      repeat (10) @(posedge core_clk_i);
      wr(`ARL_OFS_CSR, 8'h00);
      rd(`ARL_OFS_CNT, 8'hfd, 8'hff, 1'b0);
      chk_irq(1'b0);
      wr(`ARL_OFS_CSR, 8'h02);
      chk_irq(1'b1);
      rd(`ARL_OFS_CSR, 8'h03, 8'h03, 1'b0);
      rd(`ARL_OFS_CSR, 8'h02, 8'h02, 1'b0);
      chk_irq(1'b0);
      rd(`ARL_OFS_IRQ_STAT, 8'h01, 8'h01, 1'b0);
      wr(`ARL_OFS_IRQ_STAT, 8'h01);
      rd(`ARL_OFS_IRQ_STAT, 8'h00, 8'h00, 1'b0);
      $display("test overflow done");
      // external clock: five edges make five counts while the core clock runs on
      wr(`ARL_OFS_RELOAD, 8'h00);
      wr(`ARL_OFS_CSR, 8'h8c);
      pm.pulses(5);
      wr(`ARL_OFS_CSR, 8'h80);
      rd(`ARL_OFS_CNT, 8'h05, 8'h05, 1'b0);
      $display("test ext clock done");
      // captures in halt: ch0 rising, ch1 falling, both enabled
      @(posedge core_clk_i) halt <= 1'b1;
      wr(`ARL_OFS_IRQ_MASK, 8'h06);
      wr(`ARL_OFS_CAP, 8'h0d);
      pm.set_pins(2'b11);
      chk_irq(1'b1);
      rd(`ARL_OFS_CAP, 8'h1d, 8'h1d, 1'b0);
      rd(`ARL_OFS_IRQ_STAT, 8'h02, 8'h02, 1'b0);
      wr(`ARL_OFS_IRQ_STAT, 8'h02);
      chk_irq(1'b0);
      pm.set_pins(2'b10);
      rd(`ARL_OFS_IRQ_STAT, 8'h00, 8'h00, 1'b0);
      pm.set_pins(2'b00);
      rd(`ARL_OFS_IRQ_STAT, 8'h04, 8'h04, 1'b0);
      wr(`ARL_OFS_CAP, 8'h05);
      chk_irq(1'b0);
      wr(`ARL_OFS_CAP, 8'h0d);
      chk_irq(1'b1);
      wr(`ARL_OFS_IRQ_MASK, 8'h02);
      chk_irq(1'b0);
      wr(`ARL_OFS_IRQ_STAT, 8'h04);
      // out of halt with the timer stopped no edge is sampled
      @(posedge core_clk_i) halt <= 1'b0;
      pm.set_pins(2'b01);
      rd(`ARL_OFS_IRQ_STAT, 8'h00, 8'h00, 1'b0);
      $display("test capture done");
      wrap_up();
   end
endmodule
